// [include/oac_pkg.sv]
// Package holding the constants and carrier types of the operand address decoder.
package oac_pkg;

  // --------------------------------------------------------------------------
  // Word layout
  // --------------------------------------------------------------------------
  localparam int WORD_W = 36;
  localparam int HALF_W = 18;
  localparam int SECT_W = 12;
  localparam int ADDR_W = SECT_W + HALF_W;
  localparam int ACN_W = 4;
  localparam int OPC_W = 9;
  localparam int OPC_LSB = 27;
  localparam int ACF_LSB = 23;
  localparam int IND_BIT = 22;
  localparam int XRF_LSB = 18;
  localparam int ADF_LSB = 0;
  localparam int AC_SEQ_N = 4;

  // --------------------------------------------------------------------------
  // Mode and opcode encodings
  // --------------------------------------------------------------------------
  localparam logic [1:0] MODE_IMM = 2'h1;
  localparam logic [1:0] MODE_SELF = 2'h3;
  localparam logic [OPC_W-1:0] IMM_LEFT_MASK = 9'h1FC;
  localparam logic [OPC_W-1:0] IMM_LEFT_VAL = 9'h084;
  localparam logic [OPC_W-1:0] OPC_EXEC_DEF = 9'h1FE;
  localparam logic [OPC_W-1:0] OPC_EXTEND_DEF = 9'h1FF;
  localparam logic [ACN_W-1:0] NO_XR = 4'h0;
  localparam logic [3:0] EXEC_DEPTH_MAX = 4'hF;

  // --------------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic [1:0] mode;
    logic [ACN_W-1:0] ac_field;
    logic ac_used;
    logic [ACN_W-1:0] selected_accumulator;
    logic [AC_SEQ_N*ACN_W-1:0] ac_seq;
    logic [ADDR_W-1:0] ea;
    logic [HALF_W-1:0] e_r;
    logic [ADDR_W-1:0] ea_next;
    logic [WORD_W-1:0] imm_word;
    logic extended;
    logic [ADDR_W-1:0] first_word_eff_addr;
    logic [ADDR_W-1:0] second_word_eff_addr;
    logic [OPC_W-1:0] ext_opcode;
    logic executed;
  } oac_dec_t;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
  } oac_rd_req_t;

endpackage : oac_pkg

// [design/oac_ac_seq.sv]
// Successive accumulator numbers counted from the accumulator field.
`timescale 1ns/1ps
module oac_ac_seq #(
  parameter int N = oac_pkg::AC_SEQ_N
) (
  input wire logic [oac_pkg::ACN_W-1:0] ac_field,
  output logic [N*oac_pkg::ACN_W-1:0] ac_seq
);

  // --------------------------------------------------------------------------
  // Modulo sixteen sequence
  // --------------------------------------------------------------------------
  // The four bit sum drops its carry, so the successor of 17 octal is 0.
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_seq
      assign ac_seq[i*oac_pkg::ACN_W +: oac_pkg::ACN_W] = ac_field + oac_pkg::ACN_W'(i);
    end
  endgenerate

endmodule : oac_ac_seq

// [design/oac_decoder.sv]
// Instruction fetch, effective address calculation and operand addressing.
`timescale 1ns/1ps
module oac_decoder #(
  parameter logic [oac_pkg::OPC_W-1:0] OPC_EXEC = oac_pkg::OPC_EXEC_DEF,
  parameter logic [oac_pkg::OPC_W-1:0] OPC_EXTEND = oac_pkg::OPC_EXTEND_DEF,
  parameter bit EXT_ADDR = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [oac_pkg::ADDR_W-1:0] pc,
  input wire logic event_req,
  input wire logic [oac_pkg::ADDR_W-1:0] event_addr,
  input wire logic local_ref,
  output logic mem_rd_req,
  output logic [oac_pkg::ADDR_W-1:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [oac_pkg::WORD_W-1:0] mem_rd_data,
  output logic xr_rd_req,
  output logic [oac_pkg::ACN_W-1:0] xr_rd_addr,
  input wire logic xr_rd_valid,
  input wire logic [oac_pkg::WORD_W-1:0] xr_rd_data,
  output logic busy,
  output logic dec_valid,
  output oac_pkg::oac_dec_t dec,
  output logic [oac_pkg::ADDR_W-1:0] resume_pc
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CALC, S_XR, S_IND, S_OUT} oac_state_t;
  typedef enum logic [1:0] {P_INSTR, P_EXEC, P_EXTWORD} oac_purpose_t;

  oac_state_t state_ff, nxt_state;
  oac_purpose_t purpose_ff, nxt_purpose;
  logic [oac_pkg::WORD_W-1:0] inst_ff, nxt_inst;
  logic [oac_pkg::WORD_W-1:0] calc_ff, nxt_calc;
  logic [oac_pkg::ADDR_W-1:0] ea_ff, nxt_ea;
  logic [oac_pkg::ADDR_W-1:0] e0_ff, nxt_e0;
  logic [oac_pkg::OPC_W-1:0] ext_opc_ff, nxt_ext_opc;
  logic ext_ff, nxt_ext;
  logic exec_ff, nxt_exec;
  logic [3:0] depth_ff, nxt_depth;
  logic [oac_pkg::ADDR_W-1:0] ret_pc_ff, nxt_ret_pc;
  logic [oac_pkg::SECT_W-1:0] sect_ff, nxt_sect;
  logic mem_req_ff, nxt_mem_req;
  logic [oac_pkg::ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
  logic xr_req_ff, nxt_xr_req;
  logic [oac_pkg::ACN_W-1:0] xr_addr_ff, nxt_xr_addr;
  logic busy_ff, nxt_busy;
  logic valid_ff, nxt_valid;
  oac_pkg::oac_dec_t dec_ff, nxt_dec;

  // --------------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------------
  wire logic [oac_pkg::OPC_W-1:0] opcode = inst_ff[oac_pkg::OPC_LSB +: oac_pkg::OPC_W];
  wire logic [1:0] mode = opcode[1:0];
  wire logic [oac_pkg::ACN_W-1:0] ac_field = inst_ff[oac_pkg::ACF_LSB +: oac_pkg::ACN_W];
  wire logic calc_ind = calc_ff[oac_pkg::IND_BIT];
  wire logic [oac_pkg::ACN_W-1:0] calc_xr = calc_ff[oac_pkg::XRF_LSB +: oac_pkg::ACN_W];
  wire logic [oac_pkg::HALF_W-1:0] calc_y = calc_ff[oac_pkg::ADF_LSB +: oac_pkg::HALF_W];
  wire logic has_xr = calc_xr != oac_pkg::NO_XR;
  wire logic sect_zero = sect_ff == '0;
  wire logic is_exec = opcode == OPC_EXEC;
  wire logic is_extend = (opcode == OPC_EXTEND) && !ext_ff;
  wire logic imm_left = (opcode & oac_pkg::IMM_LEFT_MASK) == oac_pkg::IMM_LEFT_VAL;

  // --------------------------------------------------------------------------
  // Address arithmetic
  // --------------------------------------------------------------------------
  // Without extended addressing the section stays zero, so the in-section part is the whole address.
  wire logic [oac_pkg::SECT_W-1:0] start_sect = EXT_ADDR ? pc[oac_pkg::ADDR_W-1:oac_pkg::HALF_W] : '0;
  wire logic depth_full = depth_ff == oac_pkg::EXEC_DEPTH_MAX;
  wire logic [oac_pkg::HALF_W-1:0] indexed_y = calc_y + xr_rd_data[oac_pkg::HALF_W-1:0];
  wire logic [oac_pkg::HALF_W-1:0] e_r = ea_ff[oac_pkg::HALF_W-1:0];
  wire logic [oac_pkg::HALF_W-1:0] e_r_inc = e_r + oac_pkg::HALF_W'(1);
  wire logic wrap_local = sect_zero || local_ref || !EXT_ADDR;
  wire logic [oac_pkg::ADDR_W-1:0] ea_next = wrap_local ? {ea_ff[oac_pkg::ADDR_W-1:oac_pkg::HALF_W], e_r_inc}
    : ea_ff + oac_pkg::ADDR_W'(1);
  wire logic [oac_pkg::WORD_W-1:0] imm_word = imm_left ? {e_r, oac_pkg::HALF_W'(0)}
    : {oac_pkg::HALF_W'(0), e_r};
  wire logic ac_cond = mode == oac_pkg::MODE_SELF;
  wire logic ac_used = !(ac_cond && ac_field == '0);
  wire logic [oac_pkg::AC_SEQ_N*oac_pkg::ACN_W-1:0] ac_seq;

  oac_ac_seq #(
    .N(oac_pkg::AC_SEQ_N)
  ) u_ac_seq (
    .ac_field(ac_field),
    .ac_seq(ac_seq)
  );

  // --------------------------------------------------------------------------
  // Decoded result
  // --------------------------------------------------------------------------
  // The result is built from the latched words, plus the live local_ref input for ea_next, so every field reported
  // agrees with the address that was formed from them.
  oac_pkg::oac_dec_t out_dec;
  assign out_dec = '{
    opcode: opcode,
    mode: mode,
    ac_field: ac_field,
    ac_used: ac_used,
    selected_accumulator: ac_field,
    ac_seq: ac_seq,
    ea: ea_ff,
    e_r: e_r,
    ea_next: ea_next,
    imm_word: imm_word,
    extended: ext_ff,
    first_word_eff_addr: ext_ff ? e0_ff : ea_ff,
    second_word_eff_addr: ext_ff ? ea_ff : '0,
    ext_opcode: ext_ff ? ext_opc_ff : '0,
    executed: exec_ff
  };

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // The address words are latched copies, so nothing stored by the decoded
  // instruction can reach the address already being formed from them.
  always_comb begin
    nxt_state = state_ff;
    nxt_purpose = purpose_ff;
    nxt_inst = inst_ff;
    nxt_calc = calc_ff;
    nxt_ea = ea_ff;
    nxt_e0 = e0_ff;
    nxt_ext_opc = ext_opc_ff;
    nxt_ext = ext_ff;
    nxt_exec = exec_ff;
    nxt_depth = depth_ff;
    nxt_ret_pc = ret_pc_ff;
    nxt_sect = sect_ff;
    nxt_mem_req = 1'b0;
    nxt_mem_addr = mem_addr_ff;
    nxt_xr_req = 1'b0;
    nxt_xr_addr = xr_addr_ff;
    nxt_busy = busy_ff;
    nxt_valid = 1'b0;
    nxt_dec = dec_ff;
    case (state_ff)
      S_IDLE: begin
        if (event_req) begin
          nxt_mem_req = 1'b1;
          nxt_mem_addr = event_addr;
          nxt_ret_pc = pc;
          nxt_exec = 1'b1;
        end else if (start) begin
          nxt_mem_req = 1'b1;
          nxt_mem_addr = pc;
          nxt_ret_pc = pc + oac_pkg::ADDR_W'(1);
          nxt_exec = 1'b0;
        end
        if (event_req || start) begin
          nxt_sect = start_sect;
          nxt_purpose = P_INSTR;
          nxt_ext = 1'b0;
          nxt_depth = '0;
          nxt_busy = 1'b1;
          nxt_state = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_rd_valid) begin
          nxt_calc = mem_rd_data;
          if (purpose_ff == P_EXTWORD) begin
            nxt_ext_opc = mem_rd_data[oac_pkg::OPC_LSB +: oac_pkg::OPC_W];
          end else begin
            nxt_inst = mem_rd_data;
          end
          nxt_state = S_CALC;
        end
      end
      S_CALC: begin
        nxt_ea = {sect_ff, calc_y};
        if (has_xr) begin
          nxt_xr_req = 1'b1;
          nxt_xr_addr = calc_xr;
          nxt_state = S_XR;
        end else if (calc_ind) begin
          nxt_mem_req = 1'b1;
          nxt_mem_addr = {sect_ff, calc_y};
          nxt_state = S_IND;
        end else begin
          nxt_state = S_OUT;
        end
      end
      S_XR: begin
        if (xr_rd_valid) begin
          nxt_ea = {sect_ff, indexed_y};
          if (calc_ind) begin
            nxt_mem_req = 1'b1;
            nxt_mem_addr = {sect_ff, indexed_y};
            nxt_state = S_IND;
          end else begin
            nxt_state = S_OUT;
          end
        end
      end
      S_IND: begin
        if (mem_rd_valid) begin
          nxt_calc = mem_rd_data;
          nxt_state = S_CALC;
        end
      end
      S_OUT: begin
        // Only a finished address lets the instruction take any further step.
        // A chain of execute words is cut at the depth limit, so a word that executes itself
        // cannot hang the decoder; the execute word at the limit is reported instead.
        if (is_exec && !depth_full) begin
          nxt_mem_req = 1'b1;
          nxt_mem_addr = ea_ff;
          nxt_exec = 1'b1;
          nxt_depth = depth_ff + 4'h1;
          nxt_purpose = P_EXEC;
          nxt_state = S_FETCH;
        end else if (is_extend) begin
          nxt_e0 = ea_ff;
          nxt_ext = 1'b1;
          nxt_mem_req = 1'b1;
          nxt_mem_addr = ea_ff;
          nxt_purpose = P_EXTWORD;
          nxt_state = S_FETCH;
        end else begin
          nxt_dec = out_dec;
          nxt_valid = 1'b1;
          nxt_busy = 1'b0;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= S_IDLE;
      purpose_ff <= P_INSTR;
      inst_ff <= '0;
      calc_ff <= '0;
      ea_ff <= '0;
      e0_ff <= '0;
      ext_opc_ff <= '0;
      ext_ff <= 1'b0;
      exec_ff <= 1'b0;
      depth_ff <= '0;
      ret_pc_ff <= '0;
      sect_ff <= '0;
      mem_req_ff <= 1'b0;
      mem_addr_ff <= '0;
      xr_req_ff <= 1'b0;
      xr_addr_ff <= '0;
      busy_ff <= 1'b0;
      valid_ff <= 1'b0;
      dec_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      purpose_ff <= nxt_purpose;
      inst_ff <= nxt_inst;
      calc_ff <= nxt_calc;
      ea_ff <= nxt_ea;
      e0_ff <= nxt_e0;
      ext_opc_ff <= nxt_ext_opc;
      ext_ff <= nxt_ext;
      exec_ff <= nxt_exec;
      depth_ff <= nxt_depth;
      ret_pc_ff <= nxt_ret_pc;
      sect_ff <= nxt_sect;
      mem_req_ff <= nxt_mem_req;
      mem_addr_ff <= nxt_mem_addr;
      xr_req_ff <= nxt_xr_req;
      xr_addr_ff <= nxt_xr_addr;
      busy_ff <= nxt_busy;
      valid_ff <= nxt_valid;
      dec_ff <= nxt_dec;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign mem_rd_req = mem_req_ff;
  assign mem_rd_addr = mem_addr_ff;
  assign xr_rd_req = xr_req_ff;
  assign xr_rd_addr = xr_addr_ff;
  assign busy = busy_ff;
  assign dec_valid = valid_ff;
  assign dec = dec_ff;
  assign resume_pc = ret_pc_ff;

endmodule : oac_decoder

// [dv/oac_chk.sv]
// Checker of the decoder port behaviour.
`timescale 1ns/1ps
module oac_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire logic event_req,
  input wire logic [29:0] pc,
  input wire logic [29:0] event_addr,
  input wire logic local_ref,
  input wire logic busy,
  input wire logic mem_rd_req,
  input wire logic [29:0] mem_rd_addr,
  input wire logic dec_valid,
  input wire oac_pkg::oac_dec_t dec
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // The decode-done cycle is left out, although the idle state begins in that same cycle.
  logic go;
  assign go = clk_en && !busy && !dec_valid && (start || event_req);
  chk_fetch_pc: assert property (go && !event_req |=> mem_rd_req && mem_rd_addr == $past(pc))
    else $error("fetch not at pc");
  chk_fetch_event: assert property (go && event_req |=> mem_rd_req && mem_rd_addr == $past(event_addr))
    else $error("fetch not at event address");
  chk_ea_first: assert property (dec_valid |-> $past(busy) && $past(busy, 3))
    else $error("decode without address phase");
  chk_mode_field: assert property (dec_valid |-> dec.mode == dec.opcode[1:0])
    else $error("mode not from opcode");
  chk_sect_part: assert property (dec_valid |-> dec.e_r == dec.ea[17:0])
    else $error("in-section part wrong");
  chk_wrap_next: assert property (dec_valid && (local_ref || dec.ea[29:18] == 12'h000) |->
    dec.ea_next == {dec.ea[29:18], dec.ea[17:0] + 18'h1}) else $error("second word no wrap");
  chk_ac_modulo: assert property (dec_valid |-> dec.ac_seq[7:4] == dec.ac_field + 4'h1 &&
    dec.ac_seq[15:12] == dec.ac_field + 4'h3) else $error("accumulator sequence wrong");
  chk_no_acc: assert property (dec_valid |->
    dec.ac_used == !(dec.mode == oac_pkg::MODE_SELF && dec.ac_field == 4'h0)) else $error("ac use wrong");
  chk_imm_right: assert property (dec_valid && dec.mode == oac_pkg::MODE_IMM &&
    (dec.opcode & oac_pkg::IMM_LEFT_MASK) != oac_pkg::IMM_LEFT_VAL |-> dec.imm_word == {18'h0, dec.e_r})
    else $error("immediate word wrong");
  chk_dec_hold: assert property (!dec_valid |-> $stable(dec))
    else $error("decoded result changed");
  cov_exec: cover property (dec_valid && dec.executed);
  cov_ext: cover property (dec_valid && dec.extended);
  cov_noac: cover property (dec_valid && !dec.ac_used);
endmodule : oac_chk

bind oac_decoder oac_chk oac_chk_i (.core_clk, .reset, .clk_en, .start, .event_req, .pc, .event_addr,
  .local_ref, .busy, .mem_rd_req, .mem_rd_addr, .dec_valid, .dec);

// [dv/oac_mem_model.sv]
// Model of main memory and index registers answering reads.
`timescale 1ns/1ps
module oac_mem_model (
  input wire logic core_clk,
  input wire logic mem_rd_req,
  input wire logic [29:0] mem_rd_addr,
  output logic mem_rd_valid,
  output logic [35:0] mem_rd_data,
  input wire logic xr_rd_req,
  input wire logic [3:0] xr_rd_addr,
  output logic xr_rd_valid,
  output logic [35:0] xr_rd_data
);
  // ----------------------------------------------------------------
  // Storage and answers
  // ----------------------------------------------------------------
  logic [35:0] mem [logic [29:0]];
  logic [35:0] xr [16];
  int lat = 1;
  initial begin
    mem_rd_valid = 1'b0;
    xr_rd_valid = 1'b0;
    mem_rd_data = 36'h0;
    xr_rd_data = 36'h0;
  end
  // After a valid cycle the data shows the inverted word, so a late sample is caught.
  always @(posedge core_clk) begin
    if (mem_rd_req === 1'b1) begin
      repeat (lat - 1) @(posedge core_clk);
      #1;
      mem_rd_valid = 1'b1;
      mem_rd_data = mem.exists(mem_rd_addr) ? mem[mem_rd_addr] : 36'h0;
      @(posedge core_clk);
      #1;
      mem_rd_valid = 1'b0;
      mem_rd_data = ~mem_rd_data;
    end
  end
  always @(posedge core_clk) begin
    if (xr_rd_req === 1'b1) begin
      repeat (lat - 1) @(posedge core_clk);
      #1;
      xr_rd_valid = 1'b1;
      xr_rd_data = xr[xr_rd_addr];
      @(posedge core_clk);
      #1;
      xr_rd_valid = 1'b0;
      xr_rd_data = ~xr_rd_data;
    end
  end
endmodule : oac_mem_model

// [dv/tb_top.sv]
// Self-checking bench of the decoder.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  logic event_req = 1'b0;
  logic local_ref = 1'b0;
  logic [29:0] pc = 30'h0;
  logic [29:0] event_addr = 30'h0;
  logic mem_rd_req, mem_rd_valid, xr_rd_req, xr_rd_valid, busy, dec_valid;
  logic [29:0] mem_rd_addr, resume_pc;
  logic [35:0] mem_rd_data, xr_rd_data;
  logic [3:0] xr_rd_addr;
  oac_pkg::oac_dec_t dec;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 core_clk = ~core_clk;
  oac_decoder oac_decoder_i (.core_clk, .reset, .clk_en, .start, .pc, .event_req, .event_addr, .local_ref,
    .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .xr_rd_req, .xr_rd_addr, .xr_rd_valid,
    .xr_rd_data, .busy, .dec_valid, .dec, .resume_pc);
  oac_mem_model oac_mem_model_i (.core_clk, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
    .xr_rd_req, .xr_rd_addr, .xr_rd_valid, .xr_rd_data);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic compare(input logic [35:0] got, input logic [35:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : compare
  function automatic logic [35:0] mkw(input logic [8:0] op, input logic [3:0] ac, input logic ind,
    input logic [3:0] x, input logic [17:0] y);
    return {op, ac, ind, x, y};
  endfunction : mkw
  task automatic run_op(input logic [29:0] a, input logic [35:0] w, input logic ev, input logic lr);
    int n;
    oac_mem_model_i.mem[a] = w;
    @(posedge core_clk);
    #1;
    local_ref = lr;
    pc = ev ? 30'h0000F0 : a;
    event_addr = a;
    event_req = ev;
    start = 1'b1;
    @(posedge core_clk);
    #1;
    start = 1'b0;
    event_req = 1'b0;
    n = 0;
    while (dec_valid !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    compare(n < 300, 1'b1, "done");
  endtask : run_op
  task automatic t_plain;
    run_op(30'h000100, mkw(9'h080, 4'h5, 1'b0, 4'h0, 18'h01234), 1'b0, 1'b0);
    compare(dec.opcode, 9'h080, "opcode");
    compare(dec.ea, 30'h001234, "ea");
    compare(dec.ac_seq, 16'h8765, "acs");
    compare(resume_pc, 30'h000101, "resume");
    compare(dec.selected_accumulator, 4'h5, "acsel");
    compare(dec.ac_used, 1'b1, "acuse");
    oac_mem_model_i.mem[30'h000100] = 36'h0;
    repeat (2) @(posedge core_clk);
    #1;
    compare(dec.ea, 30'h001234, "ea kept");
  endtask : t_plain
  task automatic t_freeze;
    @(posedge core_clk);
    #1;
    clk_en = 1'b0;
    pc = 30'h000160;
    start = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    compare(busy, 1'b0, "frozen busy");
    compare(mem_rd_req, 1'b0, "frozen fetch");
    start = 1'b0;
    clk_en = 1'b1;
  endtask : t_freeze
  task automatic t_index;
    oac_mem_model_i.xr[3] = 36'h7FFFC0001;
    run_op(30'h000110, mkw(9'h080, 4'hF, 1'b0, 4'h3, 18'h3FFFE), 1'b0, 1'b0);
    compare(dec.ea, 30'h03FFFF, "ea");
    compare(dec.ea_next, 30'h0, "next");
    compare(dec.ac_seq, 16'h210F, "acs");
  endtask : t_index
  task automatic t_indirect;
    oac_mem_model_i.lat = 3;
    oac_mem_model_i.mem[30'h200] = mkw(9'h000, 4'h0, 1'b0, 4'h0, 18'h00300);
    run_op(30'h000118, mkw(9'h083, 4'h0, 1'b1, 4'h0, 18'h00200), 1'b0, 1'b0);
    oac_mem_model_i.lat = 1;
    compare(dec.ea, 30'h000300, "ea");
    compare(dec.ac_used, 1'b0, "acuse");
  endtask : t_indirect
  task automatic t_imm;
    run_op(30'h000120, mkw(9'h081, 4'h1, 1'b0, 4'h0, 18'h00055), 1'b0, 1'b0);
    compare(dec.imm_word, 36'h000000055, "imm");
    run_op(30'h000121, mkw(9'h085, 4'h1, 1'b0, 4'h0, 18'h00055), 1'b0, 1'b0);
    compare(dec.imm_word, 36'h001540000, "imml");
  endtask : t_imm
  task automatic t_exec;
    oac_mem_model_i.mem[30'h400] = mkw(9'h080, 4'h2, 1'b0, 4'h0, 18'h00010);
    run_op(30'h000130, mkw(oac_pkg::OPC_EXEC_DEF, 4'h0, 1'b0, 4'h0, 18'h00400), 1'b0, 1'b0);
    compare(dec.executed, 1'b1, "exec");
    compare(dec.ea, 30'h000010, "ea");
    compare(resume_pc, 30'h000131, "resume");
  endtask : t_exec
  task automatic t_ext;
    oac_mem_model_i.mem[30'h500] = mkw(9'h040, 4'h0, 1'b0, 4'h0, 18'h00600);
    run_op(30'h000140, mkw(oac_pkg::OPC_EXTEND_DEF, 4'h1, 1'b0, 4'h0, 18'h00500), 1'b0, 1'b0);
    compare(dec.extended, 1'b1, "ext");
    compare(dec.first_word_eff_addr, 30'h000500, "e0");
    compare(dec.second_word_eff_addr, 30'h000600, "e1");
    compare(dec.ext_opcode, 9'h040, "extop");
  endtask : t_ext
  task automatic t_event;
    run_op(30'h000700, mkw(9'h080, 4'h3, 1'b0, 4'h0, 18'h00020), 1'b1, 1'b0);
    compare(dec.ea, 30'h000020, "ea");
    compare(resume_pc, 30'h0000F0, "resume");
  endtask : t_event
  task automatic t_section;
    run_op(30'h00080800, mkw(9'h080, 4'h1, 1'b0, 4'h0, 18'h3FFFF), 1'b0, 1'b0);
    compare(dec.e_r, 18'h3FFFF, "er");
    compare(dec.ea_next, 30'h000C0000, "global");
    run_op(30'h00080810, mkw(9'h080, 4'h1, 1'b0, 4'h0, 18'h3FFFF), 1'b0, 1'b1);
    compare(dec.ea_next, 30'h00080000, "local");
  endtask : t_section
  // ----------------------------------------------------------------
  // Sequence and time limit
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_plain();
    t_index();
    t_indirect();
    t_imm();
    t_exec();
    t_ext();
    t_event();
    t_section();
    t_freeze();
    complete_run();
  end
endmodule : tb_top
